// [src/hol_loop_ctrl.sv]
// Tuning word history processor and loop control state machine
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "hol_map.svh"
module hol_loop_ctrl
    import hol_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `HOL_MS_NS / `HOL_CLK_PERIOD_NS,
    parameter int          SW         = 40
) (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [13:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [47:0] LF_TUNING_I,
    input  wire logic        LF_VALID_I,
    input  wire logic [3:0]  REF_VALID_I,
    input  wire logic        PHASE_LOCK_I,
    input  wire logic        MPP_CLEAR_I,
    output logic [47:0]      SYNTH_TUNING_O,
    output logic             HIST_STROBE_O,
    output logic             MPP_STROBE_O,
    output logic             PHASE_LOCK_O,
    output logic [1:0]       ACTIVE_REF_O,
    output logic             PROFILE_LOAD_O,
    output logic             HOLDOVER_O,
    output logic             FREERUN_O
);
    localparam int AW = 48 + SW;

    // ======================================================================
    // Registers and bus decode
    logic [47:0]    fr_q;
    logic [23:0]    avg_q;
    logic [7:0]     hcfg_q;
    logic [7:0]     loop_q;
    logic [1:0]     pincfg_q;
    logic           mask_q;
    logic           upd_q;
    logic [47:0]    res_q;
    logic           exists_q;
    logic [31:0]    rdata_q;
    logic           err_q;
    logic [31:0]    rd_mux;
    logic           mapped;
    logic [11:0]    idx;
    logic           wr;
    logic           clr_wr;

    assign idx = PADDR_I[13:2];
    assign wr  = PSEL_I & PENABLE_I & PWRITE_I;

    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        unique case (idx)
            `HOL_IDX_FR_LO:  rd_mux = fr_q[31:0];
            `HOL_IDX_FR_HI:  rd_mux = {16'h0000, fr_q[47:32]};
            `HOL_IDX_AVG:    rd_mux = {8'h00, avg_q};
            `HOL_IDX_HCFG:   rd_mux = {24'h00_0000, hcfg_q};
            `HOL_IDX_LOOP:   rd_mux = {24'h00_0000, loop_q};
            `HOL_IDX_CTRL:   rd_mux = '0;
            `HOL_IDX_PINCFG: rd_mux = {30'h0000_0000, pincfg_q};
            `HOL_IDX_STAT:   rd_mux = {30'h0000_0000, exists_q, upd_q};
            `HOL_IDX_MASK:   rd_mux = {31'h0000_0000, mask_q};
            `HOL_IDX_RES_LO: rd_mux = res_q[31:0];
            `HOL_IDX_RES_HI: rd_mux = {16'h0000, res_q[47:32]};
            default:         mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so that it comes from a flop
    // while the access phase still completes without wait states
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else if (PSEL_I && !PENABLE_I) begin
            rdata_q <= rd_mux;
            err_q   <= !mapped;
        end
    end

    assign PRDATA_O  = rdata_q;
    assign PREADY_O  = PSEL_I & PENABLE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & err_q;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fr_q     <= '0;
            avg_q    <= `HOL_AVG_RST;
            hcfg_q   <= '0;
            loop_q   <= '0;
            pincfg_q <= '0;
            mask_q   <= 1'b0;
        end else if (wr) begin
            unique case (idx)
                `HOL_IDX_FR_LO:  fr_q[31:0]  <= PWDATA_I;
                `HOL_IDX_FR_HI:  fr_q[47:32] <= PWDATA_I[15:0];
                `HOL_IDX_AVG:    avg_q       <= PWDATA_I[23:0];
                `HOL_IDX_HCFG:   hcfg_q      <= PWDATA_I[7:0];
                `HOL_IDX_LOOP:   loop_q      <= PWDATA_I[7:0];
                `HOL_IDX_PINCFG: pincfg_q    <= PWDATA_I[1:0];
                `HOL_IDX_MASK:   mask_q      <= PWDATA_I[0];
                default: ;
            endcase
        end
    end

    // History clear is a self-clearing command, never stored
    assign clr_wr = wr && idx == `HOL_IDX_CTRL && PWDATA_I[`HOL_CTRL_CLEAR];

    // Sticky update flag: a strobe in the clearing cycle wins
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= (HIST_STROBE_O & mask_q) | (upd_q & ~(wr
                     && idx == `HOL_IDX_STAT
                     && PWDATA_I[`HOL_STAT_UPD]));
        end
    end

    // ======================================================================
    // Millisecond time base
    logic [31:0] ms_cnt_q;
    logic        tick;

    assign tick = ms_cnt_q == 32'(CYC_PER_MS - 1);

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= tick ? '0 : ms_cnt_q + 1'b1;
        end
    end

    // ======================================================================
    // Loop control state machine
    hol_state_type state_q;
    hol_state_type state_d;
    logic [1:0]    active_q;
    logic [1:0]    auto_ref;
    logic [1:0]    sel_ref;
    logic          sel_ok;
    logic          user_hold;
    logic          user_free;
    logic          ref_sw;
    logic          closed;

    assign user_hold = loop_q[`HOL_LOOP_HOLD];
    assign user_free = loop_q[`HOL_LOOP_FREE];

    // Lowest valid input has the highest priority
    always_comb begin
        auto_ref = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (REF_VALID_I[i]) begin
                auto_ref = 2'(i);
            end
        end
    end

    assign sel_ref = loop_q[`HOL_LOOP_FORCE] ?
                     loop_q[`HOL_LOOP_REF_MSB:0] : auto_ref;
    assign sel_ok  = REF_VALID_I[sel_ref];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HOL_ST_FREE: begin
                if (user_hold) begin
                    state_d = HOL_ST_HOLD;
                end else if (sel_ok) begin
                    state_d = HOL_ST_ACQ;
                end
            end
            HOL_ST_ACQ: state_d = HOL_ST_CLOSED;
            HOL_ST_CLOSED: begin
                if (user_hold) begin
                    state_d = HOL_ST_HOLD;
                end else if (sel_ok && sel_ref != active_q) begin
                    state_d = HOL_ST_SWITCH;
                end else if (!REF_VALID_I[active_q]) begin
                    state_d = HOL_ST_HOLD;
                end
            end
            HOL_ST_SWITCH: state_d = HOL_ST_ACQ;
            HOL_ST_HOLD: begin
                if (!user_hold && sel_ok) begin
                    state_d = HOL_ST_ACQ;
                end
            end
        endcase
        if (user_free) begin
            state_d = HOL_ST_FREE;
        end
    end

    // Leaving free-run for a reference starts a fresh history as well
    assign ref_sw = state_d == HOL_ST_ACQ
                    && (state_q == HOL_ST_FREE
                    || (state_q != HOL_ST_ACQ && sel_ref != active_q));
    assign closed = state_q == HOL_ST_CLOSED;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q  <= HOL_ST_FREE;
            active_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_d == HOL_ST_ACQ) begin
                active_q <= sel_ref;
            end
        end
    end

    // Profile load pulses once per acquisition, then the loop closes
    assign PROFILE_LOAD_O = state_q == HOL_ST_ACQ;
    assign ACTIVE_REF_O   = active_q;
    assign HOLDOVER_O     = state_q == HOL_ST_HOLD
                            || state_q == HOL_ST_SWITCH;
    assign FREERUN_O      = state_q == HOL_ST_FREE;

    // ======================================================================
    // History accumulation
    logic [AW-1:0] acc_q;
    logic [SW-1:0] n_q;
    logic [23:0]   el_q;
    logic [23:0]   el_n;
    logic [2:0]    sh_q;
    logic          first_q;
    logic          go_q;
    logic [AW-1:0] snap_sum_q;
    logic [SW-1:0] snap_n_q;
    logic          hist_clear;
    logic          pin_clr;
    logic          div_done;
    logic [47:0]   div_quo;

    hol_sync3 u_clr_sync (
        .clk_i  (CLOCK_I),
        .rstn_i (RSTN_I),
        .d_i    (MPP_CLEAR_I),
        .q_o    (pin_clr)
    );

    assign hist_clear = clr_wr | (pin_clr & pincfg_q[`HOL_PIN_CLEAR])
                        | (ref_sw & ~hcfg_q[`HOL_HCFG_RETAIN]);
    assign el_n = el_q + 1'b1;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            acc_q      <= '0;
            n_q        <= '0;
            el_q       <= '0;
            sh_q       <= '0;
            first_q    <= 1'b1;
            go_q       <= 1'b0;
            snap_sum_q <= '0;
            snap_n_q   <= '0;
        end else begin
            go_q <= 1'b0;
            if (hist_clear || ref_sw) begin
                acc_q   <= '0;
                n_q     <= '0;
                el_q    <= '0;
                sh_q    <= hcfg_q[`HOL_HCFG_K_MSB:0];
                first_q <= hist_clear | ~exists_q;
            end else if (closed) begin
                if (LF_VALID_I) begin
                    acc_q <= acc_q + AW'(LF_TUNING_I);
                    n_q   <= n_q + 1'b1;
                end
                if (tick && el_n >= avg_q) begin
                    // Memoryless: the next interval starts from this cycle's sample alone
                    go_q       <= 1'b1;
                    snap_sum_q <= acc_q;
                    snap_n_q   <= n_q;
                    acc_q      <= LF_VALID_I ? AW'(LF_TUNING_I) : '0;
                    n_q        <= SW'(LF_VALID_I);
                    el_q       <= '0;
                    first_q    <= 1'b0;
                end else if (tick && first_q && sh_q != 3'h0
                             && el_n >= (avg_q >> sh_q)) begin
                    go_q       <= 1'b1;
                    snap_sum_q <= acc_q;
                    snap_n_q   <= n_q;
                    sh_q       <= sh_q - 1'b1;
                    el_q       <= el_n;
                end else if (tick) begin
                    el_q <= el_n;
                end
            end
        end
    end

    // An interval without samples leaves the previous result in place
    hol_div #(
        .NW (AW),
        .DW (SW),
        .QW (48)
    ) u_div (
        .clk_i   (CLOCK_I),
        .rstn_i  (RSTN_I),
        .start_i (go_q && snap_n_q != '0),
        .num_i   (snap_sum_q),
        .den_i   (snap_n_q),
        .busy_o  (),
        .done_o  (div_done),
        .quo_o   (div_quo)
    );

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            res_q         <= '0;
            exists_q      <= 1'b0;
            HIST_STROBE_O <= 1'b0;
            MPP_STROBE_O  <= 1'b0;
        end else begin
            HIST_STROBE_O <= div_done;
            MPP_STROBE_O  <= div_done & pincfg_q[`HOL_PIN_STROBE];
            if (div_done) begin
                res_q    <= div_quo;
                exists_q <= 1'b1;
            end else if (hist_clear) begin
                exists_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Tuning word selection and lock reporting
    logic [47:0] hold_pick;
    logic        entering_hold;

    assign hold_pick = exists_q ? res_q : hcfg_q[`HOL_HCFG_FALLBACK] ?
                       SYNTH_TUNING_O : fr_q;
    assign entering_hold = state_q != HOL_ST_HOLD
                           && state_q != HOL_ST_SWITCH;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SYNTH_TUNING_O <= '0;
        end else begin
            unique case (state_d)
                HOL_ST_FREE: SYNTH_TUNING_O <= fr_q;
                HOL_ST_ACQ, HOL_ST_CLOSED: begin
                    if (LF_VALID_I) begin
                        SYNTH_TUNING_O <= LF_TUNING_I;
                    end
                end
                HOL_ST_HOLD, HOL_ST_SWITCH: begin
                    if (entering_hold) begin
                        SYNTH_TUNING_O <= hold_pick;
                    end
                end
            endcase
        end
    end

    // Through a switchover the lock flag keeps its prior value
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            PHASE_LOCK_O <= 1'b0;
        end else begin
            unique case (state_d)
                HOL_ST_FREE, HOL_ST_HOLD: PHASE_LOCK_O <= 1'b0;
                HOL_ST_CLOSED: PHASE_LOCK_O <= PHASE_LOCK_I;
                HOL_ST_SWITCH, HOL_ST_ACQ: ;
            endcase
        end
    end

    // ======================================================================
    // Assertions
    a_strobe_pin_route: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        div_done && pincfg_q[`HOL_PIN_STROBE] |=> MPP_STROBE_O && HIST_STROBE_O)
        else $error("History strobe not routed to pin");

    a_strobe_status: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        HIST_STROBE_O && mask_q |=> upd_q)
        else $error("History update flag not set");

    a_hold_unlocked: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_HOLD || state_q == HOL_ST_FREE |-> !PHASE_LOCK_O)
        else $error("Lock reported in holdover or free-run");

    a_switch_lock_kept: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_CLOSED && state_d == HOL_ST_SWITCH |=>
        $stable(PHASE_LOCK_O) ##1 $stable(PHASE_LOCK_O))
        else $error("Lock flag changed during switchover");

    a_switch_brief: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_SWITCH && !user_free |=> PROFILE_LOAD_O)
        else $error("Switchover did not recover at once");

    a_user_hold_stays: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_HOLD && user_hold && !user_free |=>
        state_q == HOL_ST_HOLD)
        else $error("Left holdover while forced");

    a_free_word: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_FREE |-> SYNTH_TUNING_O == $past(fr_q))
        else $error("Free-run tuning word not applied");

    a_hold_word_const: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_HOLD && $past(state_q) == HOL_ST_HOLD |->
        $stable(SYNTH_TUNING_O))
        else $error("Holdover tuning word moved");

    a_hold_uses_hist: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        closed && state_d == HOL_ST_HOLD && exists_q |=>
        SYNTH_TUNING_O == $past(res_q))
        else $error("Holdover did not take averaged word");

    a_acq_profile: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        state_q == HOL_ST_HOLD && state_d == HOL_ST_ACQ |=>
        PROFILE_LOAD_O && ACTIVE_REF_O == $past(sel_ref))
        else $error("Recovery did not load reference profile");

    a_clear_drops: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        clr_wr && !div_done |=> !exists_q)
        else $error("History survived clear");
endmodule
`default_nettype wire

// [src/hol_map.svh]
// Register map, field positions, reset values and timing for the loop control
// Behaviour
// - Averaging interval is 24-bit millisecond count
// - Each interval's mean stored, memoryless
// - Interval end strobes; sets masked status bit
// - Strobe routable to multipurpose pin
// - Reference switch restarts and clears history
// - Control bit or pin clears history
// - Retain bit keeps history across switch
// - Without history, first value after interval
// - Count sets intermediate averages, first interval
// - Intermediates at interval over powers two
// - State machine sequences switches, applies profile
// - Software forces holdover, free-run, reference
// - Switchover passes holdover, lock state held
// - Holdover uses averaged word before entry
// - No history: free-run word or last
// - Valid reference ends holdover, profile restored
// - Forced holdover bit blocks automatic recovery
// - Holdover word keeps full 48 bits
// - Free-run uses register, closed uses filter
// - Free-run or holdover reports unlocked
`ifndef HOL_MAP_SVH
`define HOL_MAP_SVH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define HOL_IDX_FR_LO      12'h300
`define HOL_IDX_FR_HI      12'h301
`define HOL_IDX_AVG        12'h318
`define HOL_IDX_HCFG       12'h31B
`define HOL_IDX_LOOP       12'hA01
`define HOL_IDX_CTRL       12'hA03
`define HOL_IDX_PINCFG     12'hA05
`define HOL_IDX_STAT       12'hA06
`define HOL_IDX_MASK       12'hA07
`define HOL_IDX_RES_LO     12'hD14
`define HOL_IDX_RES_HI     12'hD15

// ==========================================================================
// Field positions
`define HOL_HCFG_K_MSB     2
`define HOL_HCFG_RETAIN    3
`define HOL_HCFG_FALLBACK  4
`define HOL_LOOP_HOLD      6
`define HOL_LOOP_FREE      5
`define HOL_LOOP_FORCE     4
`define HOL_LOOP_REF_MSB   1
`define HOL_CTRL_CLEAR     2
`define HOL_PIN_STROBE     0
`define HOL_PIN_CLEAR      1
`define HOL_STAT_UPD       0
`define HOL_STAT_EXIST     1

// ==========================================================================
// Reset values
`define HOL_AVG_RST        24'h00_0001

// ==========================================================================
// Timing
`define HOL_CLK_PERIOD_NS  40
`define HOL_MS_NS          1000000

`endif

// [src/hol_pkg.sv]
// Types shared by the loop control design
package hol_pkg;

    typedef enum logic [2:0] {
        HOL_ST_FREE,
        HOL_ST_ACQ,
        HOL_ST_CLOSED,
        HOL_ST_SWITCH,
        HOL_ST_HOLD
    } hol_state_type;

endpackage

// [src/hol_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module hol_sync3 (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // A change counts only once the last two stages agree
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_o <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// [src/hol_div.sv]
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module hol_div #(
    parameter int NW = 88,
    parameter int DW = 40,
    parameter int QW = 48
) (
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire logic          start_i,
    input  wire logic [NW-1:0] num_i,
    input  wire logic [DW-1:0] den_i,
    output logic               busy_o,
    output logic               done_o,
    output logic [QW-1:0]      quo_o
);
    localparam int CW = $clog2(NW + 1);

    logic [NW-1:0] num_q;
    logic [DW:0]   rem_q;
    logic [DW-1:0] den_q;
    logic [CW-1:0] cnt_q;
    logic [DW:0]   rem_sh;
    logic          ge;

    assign rem_sh = {rem_q[DW-1:0], num_q[NW-1]};
    assign ge     = rem_sh >= {1'b0, den_q};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            num_q  <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            quo_o  <= '0;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && start_i) begin
                num_q  <= num_i;
                den_q  <= den_i;
                rem_q  <= '0;
                cnt_q  <= CW'(NW);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                rem_q <= ge ? rem_sh - {1'b0, den_q} : rem_sh;
                num_q <= {num_q[NW-2:0], ge};
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CW'(1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    quo_o  <= {num_q[QW-2:0], ge};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/hol_loop_ctrl_tb_top.sv]
// Self-checking testbench for the loop control block
`timescale 1ns/1ns
`default_nettype none
`include "hol_map.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module hol_loop_ctrl_tb_top;
    localparam logic [47:0] LFV = 48'h1234_5678_9ABC;
    localparam logic [47:0] FRV = 48'h0BAD_0000_F00D;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] synth;
    logic        strobe, mstrobe, lock, pload, hold, free, plk, mclr;
    logic [1:0]  aref;
    logic [3:0]  refv;
    int          err_count, cmp_count, gap;

    hol_loop_ctrl #(.CYC_PER_MS(10)) DUT (
        .CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .LF_TUNING_I(LFV), .LF_VALID_I(1'b1), .REF_VALID_I(refv),
        .PHASE_LOCK_I(plk), .MPP_CLEAR_I(mclr), .SYNTH_TUNING_O(synth),
        .HIST_STROBE_O(strobe), .MPP_STROBE_O(mstrobe), .PHASE_LOCK_O(lock),
        .ACTIVE_REF_O(aref), .PROFILE_LOAD_O(pload), .HOLDOVER_O(hold),
        .FREERUN_O(free));

    // ==========================================================
    // Bus and timing helpers
    task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts edges up to the next strobe; pin copy must match it
    task next_strobe;
        gap = 0;
        do begin
            @(posedge clk);
            gap++;
        end while (strobe !== 1'b1 && gap < 1000);
        `CHK("pin strobe", 1'b1, mstrobe)
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task t_regs;
        apb(1'b0, `HOL_IDX_AVG, 32'h0000_0000);
        `CHK("interval reset", 32'h0000_0001, rd)
        apb(1'b0, 12'h123, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, `HOL_IDX_FR_LO, FRV[31:0]);
        apb(1'b1, `HOL_IDX_FR_HI, {16'h0000, FRV[47:32]});
        repeat (3) @(posedge clk);
        `CHK("freerun word", FRV, synth)
        `CHK("freerun lock", 1'b0, lock)
    endtask

    // K=2 gives averages at T/4, T/2, T, then every T (T = 400 cycles);
    // T/4 must exceed the divide time or an average is lost
    task t_hist;
        apb(1'b1, `HOL_IDX_AVG, 32'h0000_0028);
        apb(1'b1, `HOL_IDX_HCFG, 32'h0000_0002);
        apb(1'b1, `HOL_IDX_MASK, 32'h0000_0001);
        apb(1'b1, `HOL_IDX_PINCFG, 32'h0000_0001);
        refv <= 4'h1;
        next_strobe();
        next_strobe();
        `CHK("gap T/4", 100, gap)
        next_strobe();
        `CHK("gap T/2", 200, gap)
        next_strobe();
        `CHK("gap T", 400, gap)
        apb(1'b0, `HOL_IDX_RES_LO, 32'h0000_0000);
        `CHK("avg low", LFV[31:0], rd)
        apb(1'b0, `HOL_IDX_RES_HI, 32'h0000_0000);
        `CHK("avg high", LFV[47:32], rd[15:0])
        apb(1'b0, `HOL_IDX_STAT, 32'h0000_0000);
        `CHK("status", 2'b11, rd[1:0])
    endtask

    task t_hold;
        apb(1'b1, `HOL_IDX_LOOP, 32'h0000_0040);
        repeat (6) @(posedge clk);
        `CHK("holdover", 1'b1, hold)
        `CHK("hold word", LFV, synth)
        `CHK("hold lock", 1'b0, lock)
        apb(1'b1, `HOL_IDX_LOOP, 32'h0000_0000);
        repeat (6) @(posedge clk);
        `CHK("recovered", 1'b0, hold)
    endtask

    task t_clear;
        apb(1'b1, `HOL_IDX_CTRL, 32'h0000_0004);
        apb(1'b1, `HOL_IDX_LOOP, 32'h0000_0040);
        apb(1'b0, `HOL_IDX_STAT, 32'h0000_0000);
        `CHK("exists", 1'b0, rd[1])
        repeat (6) @(posedge clk);
        `CHK("no history word", FRV, synth)
        apb(1'b1, `HOL_IDX_LOOP, 32'h0000_0020);
        repeat (6) @(posedge clk);
        `CHK("forced free", 1'b1, free)
        `CHK("free word", FRV, synth)
    endtask

    // Retain keeps history over a switch; pin clear and plain switch drop it
    task t_switch;
        apb(1'b1, `HOL_IDX_LOOP, 32'h0000_0000);
        next_strobe();
        apb(1'b1, `HOL_IDX_HCFG, 32'h0000_000A);
        refv <= 4'h2;
        plk <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("switch hold", 1'b1, hold)
        `CHK("switch lock", 1'b1, lock)
        @(posedge clk);
        `CHK("profile load", 1'b1, pload)
        @(posedge clk);
        `CHK("new ref", 2'h1, aref)
        apb(1'b0, `HOL_IDX_STAT, 32'h0000_0000);
        `CHK("retained", 1'b1, rd[1])
        apb(1'b1, `HOL_IDX_PINCFG, 32'h0000_0003);
        mclr <= 1'b1;
        repeat (5) @(posedge clk);
        mclr <= 1'b0;
        apb(1'b0, `HOL_IDX_STAT, 32'h0000_0000);
        `CHK("pin clear", 1'b0, rd[1])
        next_strobe();
        apb(1'b1, `HOL_IDX_HCFG, 32'h0000_0002);
        refv <= 4'h1;
        repeat (4) @(posedge clk);
        apb(1'b0, `HOL_IDX_STAT, 32'h0000_0000);
        `CHK("dropped", 1'b0, rd[1])
    endtask

    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, refv, mclr} = '0;
        plk = 1'b1;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_hist();
        t_hold();
        t_clear();
        t_switch();
        summarize();
    end

    initial begin
        #(40 * 5000);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
